/* File: cidsb_pkg.sv */
// Purpose: shared constants and types for the instruction decode subset core
// Assumes: 8-bit data, 16-bit address, one bus clock
// Notes: cycle codes follow the per-cycle bus activity of the core
package cidsb_pkg;
  localparam logic [7:0] OP_INDEX_TO_STACK = 8'h94;
  localparam logic [7:0] OP_STACK_TO_INDEX = 8'h95;
  localparam logic [7:0] OP_WAIT = 8'h8F;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE;
  localparam logic [7:0] VECTOR_PAGE = 8'hFF;
  localparam logic [7:0] ZERO_PAGE = 8'h00;
  localparam logic [15:0] SP_RESET = 16'h00FF;
  localparam logic [7:0] CCR_RESET = 8'h68;
  localparam int CCR_V = 7;
  localparam int CCR_H = 4;
  localparam int CCR_I = 3;
  localparam int CCR_N = 2;
  localparam int CCR_Z = 1;
  localparam int CCR_C = 0;

  typedef enum logic [2:0] {
    CYC_FREE = 3'b000,
    CYC_FETCH = 3'b001,
    CYC_READ = 3'b010,
    CYC_WRITE = 3'b011,
    CYC_PUSH = 3'b100,
    CYC_POP = 3'b101,
    CYC_VECTOR = 3'b110,
    CYC_IDLE = 3'b111
  } cidsb_cyc_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
    cidsb_cyc_e code;
  } cidsb_bus_s;

  typedef struct packed {
    logic [15:0] hx;
    logic [15:0] sp;
    logic [7:0] condition_code_reg;
  } cidsb_regs_s;
endpackage : cidsb_pkg

/* File: cidsb_addr.sv */
// Purpose: effective address arithmetic for the operand modes
// Assumes: purely combinational
// Notes: shared by the core for branch, direct and indexed forms
`timescale 1ns/1ps
module cidsb_addr (
  // operands
  input wire logic [15:0] pc_next,
  input wire logic [15:0] hx,
  input wire logic [7:0] off8,
  input wire logic [15:0] off16,
  input wire logic [2:0] bitnum,
  // results
  output logic [15:0] branch_target,
  output logic [15:0] direct_addr,
  output logic [15:0] ix1_addr,
  output logic [15:0] ix2_addr,
  output logic [7:0] bit_mask
);
  import cidsb_pkg::*;
  // signed offset from the instruction after the branch, -128..+127
  assign branch_target = pc_next + {{8{off8[7]}}, off8};
  assign direct_addr = {ZERO_PAGE, off8};
  assign ix1_addr = hx + {8'h00, off8};
  assign ix2_addr = hx + off16;
  assign bit_mask = 8'h01 << bitnum;
endmodule : cidsb_addr

/* File: cidsb_core.sv */
// Purpose: fetch and execute core for index/stack transfers and wait
// Assumes: memory answers in the same cycle on RDATA for the address on PC
// Notes: unknown opcodes execute as one-fetch no-ops in this subset
`timescale 1ns/1ps
// Contract
// - opcode 94: two cycles, stack pointer gets index pair minus one, flags kept
// - opcode 8F: at least two cycles, clears interrupt mask, then halts
// - free cycle lasts one bus clock and shows as a read
// - program fetch reads next sequential location, address plus one
// - push writes one byte, pop reads one byte, operands are 8 bits
// - vectors read from top page, high byte first
// - branch adds signed 8-bit offset to next instruction address
// - direct operand byte addresses the zero page
// - 8-bit indexed offset unsigned; 16-bit offset added likewise
// - bit number 0 to 7 selects operand bit
// - post-increment indexed modes bump index pair after use
// - opcode 95: two cycles, index pair gets stack pointer plus one
module cidsb_core (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // system bus
  input wire logic [7:0] RDATA,
  output cidsb_pkg::cidsb_bus_s BUS,
  // interrupt request
  input wire logic IRQ,
  // status
  output cidsb_pkg::cidsb_regs_s REGS,
  output logic WAITING,
  output logic [15:0] PC
);
  import cidsb_pkg::*;

  // reset drives no access at all, so the bus rests on the idle code
  localparam cidsb_bus_s BUS_IDLE = '{addr: '0, wdata: '0, rd: 1'b0, wr: 1'b0, code: CYC_IDLE};

  typedef enum logic [2:0] {
    ST_VEC_HI = 3'b000,
    ST_VEC_LO = 3'b001,
    ST_FETCH = 3'b010,
    ST_EXEC = 3'b011,
    ST_WAIT = 3'b100
  } cidsb_state_e;

  ////////////////////////////////////////////////////////////////////////////
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  wire rst_n = rst_sync_r;

  ////////////////////////////////////////////////////////////////////////////
  cidsb_state_e state_r, state_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [15:0] hx_r, hx_nxt;
  logic [15:0] sp_r, sp_nxt;
  logic [7:0] ccr_r, ccr_nxt;
  logic [7:0] op_r, op_nxt;
  cidsb_bus_s bus_r, bus_nxt;
  logic waiting_r;

  wire irq_taken = IRQ && !ccr_r[CCR_I];
  wire [15:0] pc_inc = pc_r + ONE16;
  wire [15:0] vec_lo_addr = {VECTOR_PAGE, RESET_VECTOR_ADDR[7:0]} + ONE16;
  // PC doubles as the access address, so memory needs no extra address pins;
  // the vector high byte waits in op_r until the low byte arrives

  // address helpers kept for operand modes of the wider instruction set
  logic [15:0] br_tgt, dir_addr, ix1_addr, ix2_addr;
  logic [7:0] bit_mask;
  cidsb_addr u_addr (
    .pc_next(pc_inc),
    .hx(hx_r),
    .off8(RDATA),
    .off16({RDATA, RDATA}),
    .bitnum(op_r[3:1]),
    .branch_target(br_tgt),
    .direct_addr(dir_addr),
    .ix1_addr(ix1_addr),
    .ix2_addr(ix2_addr),
    .bit_mask(bit_mask)
  );

  function automatic cidsb_bus_s mk_read(input logic [15:0] a, input cidsb_cyc_e c);
    cidsb_bus_s b;
    b = '0;
    b.addr = a;
    b.rd = 1'b1;
    b.code = c;
    return b;
  endfunction : mk_read

  // opcodes that own a second, free cycle in this subset
  function automatic logic needs_exec(input logic [7:0] op);
    logic hit;
    hit = (op == OP_INDEX_TO_STACK) || (op == OP_STACK_TO_INDEX) || (op == OP_WAIT);
    return hit;
  endfunction : needs_exec

  wire fetch_multi = needs_exec(RDATA);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    hx_nxt = hx_r;
    sp_nxt = sp_r;
    ccr_nxt = ccr_r;
    op_nxt = op_r;
    bus_nxt = '0;
    bus_nxt.code = CYC_IDLE;
    case (state_r)
      ST_VEC_HI: begin
        // high byte first from the top page
        bus_nxt = mk_read({VECTOR_PAGE, RESET_VECTOR_ADDR[7:0]}, CYC_VECTOR);
        op_nxt = RDATA;
        pc_nxt = vec_lo_addr;
        state_nxt = ST_VEC_LO;
      end
      ST_VEC_LO: begin
        bus_nxt = mk_read(vec_lo_addr, CYC_VECTOR);
        pc_nxt = {op_r, RDATA};
        state_nxt = ST_FETCH;
      end
      ST_FETCH: begin
        bus_nxt = mk_read(pc_r, CYC_FETCH);
        op_nxt = RDATA;
        pc_nxt = pc_inc;
        state_nxt = fetch_multi ? ST_EXEC : ST_FETCH;
      end
      ST_EXEC: begin
        // second cycle is a free cycle, driven as a read
        bus_nxt = mk_read(pc_r, CYC_FREE);
        state_nxt = ST_FETCH;
        case (op_r)
          OP_INDEX_TO_STACK: sp_nxt = hx_r - ONE16;
          OP_STACK_TO_INDEX: hx_nxt = sp_r + ONE16;
          OP_WAIT: begin
            ccr_nxt[CCR_I] = 1'b0;
            state_nxt = ST_WAIT;
          end
          default: state_nxt = ST_FETCH;
        endcase
      end
      ST_WAIT: begin
        // bus stays idle; flags of other bits untouched
        if (irq_taken) begin
          state_nxt = ST_FETCH;
        end
      end
      default: state_nxt = ST_VEC_HI;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // one short register block per piece of state, except hx and sp which share one; all share the synced reset
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_VEC_HI;
    end else begin
      state_r <= state_nxt;
    end
  end

  // the first access after reset is the vector high byte, so PC starts there
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pc_r <= RESET_VECTOR_ADDR;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      hx_r <= '0;
      sp_r <= SP_RESET;
    end else begin
      hx_r <= hx_nxt;
      sp_r <= sp_nxt;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ccr_r <= CCR_RESET;
    end else begin
      ccr_r <= ccr_nxt;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      op_r <= '0;
    end else begin
      op_r <= op_nxt;
    end
  end

  // idle rather than all-zero: code zero is a free cycle, which must be a read
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      bus_r <= BUS_IDLE;
    end else begin
      bus_r <= bus_nxt;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      waiting_r <= 1'b0;
    end else begin
      waiting_r <= (state_nxt == ST_WAIT);
    end
  end

  assign BUS = bus_r;
  assign REGS = '{hx: hx_r, sp: sp_r, condition_code_reg: ccr_r};
  assign WAITING = waiting_r;
  assign PC = pc_r;
endmodule : cidsb_core

/* File: cidsb_props.sv */
// Purpose: bus and decode checks
// Assumes: BUS lags the access by one cycle
// Notes: bound to the core
`timescale 1ns/1ps
module cidsb_props (
  // core pins
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic [7:0] RDATA,
  input wire cidsb_pkg::cidsb_bus_s BUS,
  input wire logic IRQ,
  input wire cidsb_pkg::cidsb_regs_s REGS,
  input wire logic WAITING
);
  import cidsb_pkg::*;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  // a fetch shows one cycle late, so its opcode is the previous RDATA
  wire fe = BUS.code == CYC_FETCH;
  free_read_a: assert property ($past(fe) && BUS.code == CYC_FREE |-> BUS.rd)
    else $error("free not read");
  fetch_step_a: assert property ($past(fe) && fe |-> BUS.addr == $past(BUS.addr) + ONE16)
    else $error("fetch skipped");
  vec_order_a: assert property (
    BUS.code == CYC_VECTOR && BUS.addr == 16'hFFFE |=> BUS.addr == 16'hFFFF)
    else $error("vector order");
  stack_load_a: assert property (
    fe && $past(RDATA) == OP_INDEX_TO_STACK |-> ##[1:3] REGS.sp == REGS.hx - ONE16)
    else $error("stack load");
  index_load_a: assert property (
    fe && $past(RDATA) == OP_STACK_TO_INDEX |-> ##[1:3] REGS.hx == REGS.sp + ONE16)
    else $error("index load");
  wait_mask_a: assert property (
    fe && $past(RDATA) == OP_WAIT |-> ##[1:3] WAITING && !REGS.condition_code_reg[CCR_I])
    else $error("wait entry");
  halt_quiet_a: assert property (WAITING && $past(WAITING) |-> !BUS.rd && !BUS.wr)
    else $error("bus while halted");
  irq_wake_a: assert property (WAITING && IRQ && !REGS.condition_code_reg[CCR_I] |-> ##[1:3] !WAITING)
    else $error("no wake");
endmodule : cidsb_props
bind cidsb_core cidsb_props cidsb_props_inst (.REF_CLK(REF_CLK), .RESETN(RESETN),
  .RDATA(RDATA), .BUS(BUS), .IRQ(IRQ), .REGS(REGS), .WAITING(WAITING));

/* File: cidsb_mem.sv */
// Purpose: memory beside the core
// Assumes: PC holds the access address
// Notes: start vector is 1000
`timescale 1ns/1ps
module cidsb_mem (
  // access
  input wire logic [15:0] addr,
  output logic [7:0] rdata
);
  logic [7:0] prog [0:255] = '{default: 8'h9D};
  assign rdata = &addr[15:8] ? {3'h0, ~addr[0], 4'h0} : prog[addr[7:0]];
endmodule : cidsb_mem

/* File: tb_top.sv */
// Purpose: bench for the core
// Assumes: program runs from 1000
// Notes: accesses checked in order
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
  import cidsb_pkg::*;
  logic REF_CLK = 0, RESETN = 0, IRQ = 0, WAITING;
  logic [7:0] RDATA, op;
  logic [15:0] PC, sp = SP_RESET, hx = '0;
  logic [18:0] q [$];
  cidsb_bus_s BUS;
  cidsb_regs_s REGS;
  int n_errors = 0, total_checks = 0, seed = 90844;
  cidsb_core cidsb_core_inst (.REF_CLK(REF_CLK), .RESETN(RESETN), .RDATA(RDATA),
    .BUS(BUS), .IRQ(IRQ), .REGS(REGS), .WAITING(WAITING), .PC(PC));
  cidsb_mem cidsb_mem_inst (.addr(PC), .rdata(RDATA));
  initial forever #25 REF_CLK = ~REF_CLK;
  initial begin
    #100000;
    n_errors++;
    finish_test();
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  // rd gates the compare: reset and halt show no access at all
  always @(posedge REF_CLK) begin
    #1;
    if (BUS.rd === 1'b1 && q.size() > 0) begin
      `CHK("access", q[0], {BUS.code, BUS.code == CYC_FREE ? 16'h0000 : BUS.addr})
      `CHK("bus write", 1'b0, BUS.wr)
      q.delete(0);
    end
  end
  initial begin
    q = '{{CYC_VECTOR, 16'hFFFE}, {CYC_VECTOR, 16'hFFFF}};
    for (int i = 0; i < 11; i++) begin
      op = (i == 10) ? OP_WAIT : OP_INDEX_TO_STACK + 8'($random(seed) & 1);
      cidsb_mem_inst.prog[i] = op;
      if (op == OP_STACK_TO_INDEX) hx = sp + ONE16;
      if (op == OP_INDEX_TO_STACK) sp = hx - ONE16;
      q.push_back({CYC_FETCH, 16'h1000 + 16'(i)});
      q.push_back({CYC_FREE, 16'h0000});
    end
    q.push_back({CYC_FETCH, 16'h100B});
    q.push_back({CYC_FETCH, 16'h100C});
    #77 RESETN = 1;
    for (int n = 0; n < 100 && WAITING !== 1'b1; n++) #50;
    #300;
    `CHK("sp", sp, REGS.sp)
    `CHK("hx", hx, REGS.hx)
    `CHK("pc", 16'h100B, PC)
    `CHK("waiting", 1'b1, WAITING)
    `CHK("ccr", CCR_RESET & 8'hF7, REGS.condition_code_reg)
    IRQ = 1;
    for (int n = 0; n < 20 && WAITING !== 1'b0; n++) #50;
    IRQ = 0;
    `CHK("woken", 1'b0, WAITING)
    #300;
    `CHK("left", 0, q.size())
    $display("test transfers and wait done");
    finish_test();
  end
endmodule : tb_top
